/* logic/pmu_cfg.svh */
// offsets, field positions, reset values and timing figures of the sequencer
`ifndef PMU_CFG_SVH
`define PMU_CFG_SVH
`define PMU_CLK_HZ 50000000
`define PMU_DEBOUNCE_MS 50
`define PMU_LONGPRESS_S 15
`define PMU_PULSE_US 500
`define PMU_RAMP_US 1000
`define PMU_STEP_US 250
`define PMU_DELAY_UNIT_MS 1
`define PMU_SEQ_PINS 3'h5
`define PMU_OFS_CTRL1 8'h00
`define PMU_OFS_CTRL2 8'h04
`define PMU_OFS_AUTO 8'h08
`define PMU_OFS_MASK 8'h0c
`define PMU_OFS_DELAY 8'h10
`define PMU_OFS_LR2 8'h14
`define PMU_OFS_STATUS 8'h18
`define PMU_C1_LR1_BIT 3
`define PMU_C1_LR2_BIT 4
`define PMU_LR2_FOLLOW_BIT 6
`define PMU_RST_CTRL1 5'h00
`define PMU_RST_CTRL2 2'h0
`define PMU_RST_AUTO 2'h3
`define PMU_RST_MASK 5'h1f
`define PMU_RST_DELAY 2'h0
`define PMU_RST_LR2 7'h00
`define PMU_RESP_OKAY 2'h0
`define PMU_RESP_SLVERR 2'h2
`endif

/* logic/pmu_debounce.sv */
// level debouncer: output follows input after it has held steady
`timescale 1ns/1ps
module pmu_debounce #(
  parameter int Cycles = 2500000,
  parameter logic InitLevel = 1'b1
) (
  input wire logic clock, // system clock
  input wire logic rstN, // synchronised reset, active low
  input wire logic din, // synchronised raw level
  output logic dout // debounced level
);
  import pmu_pkg::*;
  logic [31:0] cnt_r;
  logic dout_r;

  // count cycles that differ from the output; any return to the output level restarts, so bounces never pass
  always_ff @(posedge clock or negedge rstN)
  begin
    if (!rstN)
    begin
      cnt_r <= 32'h0;
      dout_r <= InitLevel;
    end
    else if (din == dout_r)
      cnt_r <= 32'h0;
    else if (cnt_r == 32'(Cycles - 1))
    begin
      cnt_r <= 32'h0;
      dout_r <= din;
    end
    else
      cnt_r <= cnt_r + 32'h1;
  end
  assign dout = dout_r;
endmodule

/* logic/pmu_pkg.sv */
// types shared by the power-state sequencer files
package pmu_pkg;
  typedef enum logic [2:0] {
    PMU_OFF = 3'b000,
    PMU_RAMP = 3'b001,
    PMU_LOAD = 3'b010,
    PMU_UP = 3'b011,
    PMU_ON = 3'b100,
    PMU_DOWN = 3'b101
  } pmu_state_t;
  typedef logic [2:0] pmu_seq_t;
endpackage

/* logic/pmu_sequencer.sv */
// power-state sequencer with axi4-lite registers
//
// Function
// - enable pins act only in ON, pin mode
// - high enable pin starts its converter
// - low enable: converter off, discharge on
// - select field orders start/stop; pins ignored otherwise
// - linear regulators auto-start when configured
// - reset output rises after power-good delay
// - reset logic inactive in OFF
// - power-good low until masked supplies good, delayed
// - start needs valid rail and debounced button, or hold-on with external power
// - ramp rail, load defaults, then sequence; bus only ON
// - off on release without hold, or lockout
// - lockout level bits kept until OFF or the long-press pulse
// - long press pulses power-good once, rearms
// - long-press pulse restores register defaults
// - wake output low after debounced press
// - hold-on falling during press: immediate shutdown
// - hold-on with external power starts sequence
// - over-temperature disables all converters
// - regulator two enable bit, follow converter three
// - regulator one by enable bit or auto
//
// Local design decisions: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "pmu_cfg.svh"
module pmu_sequencer #(
  parameter int DebounceCycles = `PMU_DEBOUNCE_MS * (`PMU_CLK_HZ / 1000),
  parameter int LongPressCycles = `PMU_LONGPRESS_S * `PMU_CLK_HZ,
  parameter int PulseCycles = `PMU_PULSE_US * (`PMU_CLK_HZ / 1000000),
  parameter int RampCycles = `PMU_RAMP_US * (`PMU_CLK_HZ / 1000000),
  parameter int StepCycles = `PMU_STEP_US * (`PMU_CLK_HZ / 1000000),
  parameter int DelayUnitCycles = `PMU_DELAY_UNIT_MS * (`PMU_CLK_HZ / 1000)
) (
  input wire logic clock, // system clock, 50 MHz
  input wire logic nrst, // asynchronous reset, active low
  input wire logic powerButtonN, // push-button, low when pressed
  input wire logic holdOn, // hold-on from the host
  input wire logic extPowerPresent, // usb or adapter power present
  input wire logic lockoutOk, // system rail above lockout
  input wire logic overTemp, // any thermal flag
  input wire logic resetSenseHigh, // reset-sense comparator
  input wire logic [4:0] supplyGood, // bucks 1..3, linregs 1..2
  input wire logic [2:0] buckEnablePins, // buck1..3_enable pins
  input wire logic [5:0] buck3Setting, // buck 3 voltage code
  output logic [2:0] buckOn, // converter run
  output logic [2:0] buckDischarge, // output discharge switch
  output logic [1:0] linregOn, // linear regulators run
  output logic [5:0] linreg2Setting, // code used by regulator two
  output logic [1:0] lockoutLevel, // lockout level bits
  output logic sysRampOn, // system rail path on
  output logic serialActive, // register bus accepted
  output pmu_pkg::pmu_state_t powerState, // sequencer state
  output logic powerGoodOut, // open drain, data (always 0)
  output logic powerGoodOe, // drives power-good low
  output logic resetOut, // open drain, data (always 0)
  output logic resetOe, // drives reset low
  output logic buttonWakeOut, // open drain, data (always 0)
  output logic buttonWakeOe, // drives wake low
  input wire logic [7:0] awaddr, // axi write address
  input wire logic awvalid, // axi
  output logic awready, // axi
  input wire logic [31:0] wdata, // axi write data
  input wire logic [3:0] wstrb, // axi byte strobes
  input wire logic wvalid, // axi
  output logic wready, // axi
  output logic [1:0] bresp, // axi
  output logic bvalid, // axi
  input wire logic bready, // axi
  input wire logic [7:0] araddr, // axi read address
  input wire logic arvalid, // axi
  output logic arready, // axi
  output logic [31:0] rdata, // axi
  output logic [1:0] rresp, // axi
  output logic rvalid, // axi
  input wire logic rready // axi
);
  import pmu_pkg::*;

  // cumulative converter mask after a start step; stop runs it backwards
  function automatic logic [2:0] seqMask(input pmu_seq_t sel, input logic [1:0] step);
    logic [8:0] t;
    t = 9'h0;
    unique case (sel)
      3'h0: t = 9'h1ff;
      3'h1: t = {3'h7, 3'h3, 3'h1};
      3'h2: t = {3'h7, 3'h6, 3'h4};
      3'h3: t = {3'h7, 3'h5, 3'h1};
      3'h4: t = {3'h7, 3'h3, 3'h2};
      3'h5: t = 9'h0;
      3'h6: t = {3'h7, 3'h6, 3'h2};
      3'h7: t = {3'h7, 3'h5, 3'h4};
    endcase
    seqMask = (step == 2'h0) ? 3'h0 : t[3 * (step - 2'h1) +: 3];
  endfunction

  // shared delay for power-good and reset
  function automatic logic [31:0] delayCycles(input logic [1:0] sel);
    delayCycles = 32'({30'h0, sel} + 32'h1) * 32'(DelayUnitCycles);
  endfunction

  logic rstSync1_r, rstN;
  logic btnSync1_r, btnSync2_r, holdSync1_r, holdSync2_r, holdPrev_r;
  logic btnDeb;
  pmu_state_t state_r;
  logic [31:0] timer_r, longCnt_r, pulseCnt_r, pgCnt_r, rsCnt_r;
  logic [1:0] step_r;
  logic longFired_r, pulse_r, pgOk_r, rsOk_r;
  logic [4:0] ctrl1_r;
  logic [1:0] ctrl2_r, auto_r, delay_r;
  logic [4:0] mask_r;
  logic [6:0] lr2_r;
  logic awHeld_r, wHeld_r;
  logic [7:0] awAddr_r;
  logic [31:0] wData_r;
  logic [3:0] wStrb_r;
  logic doWrite, regsDefault, longStart, timerDone, pinMode, goodAll;
  pmu_seq_t seqSel;

  // reset release through two flops
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      rstSync1_r <= 1'b0;
      rstN <= 1'b0;
    end
    else
    begin
      rstSync1_r <= 1'b1;
      rstN <= rstSync1_r;
    end
  end

  // input synchronisers; first stage feeds only the second
  always_ff @(posedge clock or negedge rstN)
  begin
    if (!rstN)
    begin
      btnSync1_r <= 1'b1;
      btnSync2_r <= 1'b1;
      holdSync1_r <= 1'b0;
      holdSync2_r <= 1'b0;
      holdPrev_r <= 1'b0;
    end
    else
    begin
      btnSync1_r <= powerButtonN;
      btnSync2_r <= btnSync1_r;
      holdSync1_r <= holdOn;
      holdSync2_r <= holdSync1_r;
      holdPrev_r <= holdSync2_r;
    end
  end

  pmu_debounce #(.Cycles(DebounceCycles), .InitLevel(1'b1)) btnDebounce (
    .clock(clock),
    .rstN(rstN),
    .din(btnSync2_r),
    .dout(btnDeb)
  );

  assign seqSel = ctrl1_r[2:0];
  assign pinMode = (seqSel == `PMU_SEQ_PINS);
  assign timerDone = (timer_r == 32'h0);
  assign longStart = !btnDeb && !longFired_r && (longCnt_r == 32'(LongPressCycles - 1));
  assign regsDefault = pulse_r || (state_r == PMU_LOAD);

  // power state machine
  always_ff @(posedge clock or negedge rstN)
  begin
    if (!rstN)
    begin
      state_r <= PMU_OFF;
      timer_r <= 32'h0;
      step_r <= 2'h0;
    end
    else
    begin
      if (!timerDone)
        timer_r <= timer_r - 32'h1;
      unique case (state_r)
        PMU_OFF:
          if (lockoutOk && (!btnDeb || (holdSync2_r && extPowerPresent)))
          begin
            state_r <= PMU_RAMP;
            timer_r <= 32'(RampCycles - 1);
          end
        PMU_RAMP:
          if (!lockoutOk)
            state_r <= PMU_OFF;
          else if (timerDone)
            state_r <= PMU_LOAD;
        PMU_LOAD:
        begin
          state_r <= PMU_UP;
          step_r <= 2'h0;
          timer_r <= 32'h0;
        end
        PMU_UP, PMU_ON, PMU_DOWN:
          if (!lockoutOk || (holdPrev_r && !holdSync2_r && !btnDeb))
          begin
            state_r <= PMU_OFF;
            step_r <= 2'h0;
          end
          else if (state_r != PMU_DOWN && btnDeb && !holdSync2_r)
          begin
            state_r <= PMU_DOWN;
            timer_r <= 32'(StepCycles - 1);
          end
          else if (state_r == PMU_UP && timerDone)
          begin
            timer_r <= 32'(StepCycles - 1);
            if (step_r == 2'h3)
              state_r <= PMU_ON;
            else
              step_r <= step_r + 2'h1;
          end
          else if (state_r == PMU_DOWN && timerDone)
          begin
            timer_r <= 32'(StepCycles - 1);
            if (step_r == 2'h0)
              state_r <= PMU_OFF;
            else
              step_r <= step_r - 2'h1;
          end
        default:
          state_r <= PMU_OFF;
      endcase
    end
  end

  // long-press timer: one pulse per press, rearmed by release
  always_ff @(posedge clock or negedge rstN)
  begin
    if (!rstN)
    begin
      longCnt_r <= 32'h0;
      longFired_r <= 1'b0;
      pulseCnt_r <= 32'h0;
      pulse_r <= 1'b0;
    end
    else
    begin
      if (btnDeb)
      begin
        longCnt_r <= 32'h0;
        longFired_r <= 1'b0;
      end
      else if (longStart)
      begin
        longFired_r <= 1'b1;
        longCnt_r <= 32'h0;
      end
      else if (!longFired_r)
        longCnt_r <= longCnt_r + 32'h1;
      if (longStart)
      begin
        pulse_r <= 1'b1;
        pulseCnt_r <= 32'(PulseCycles - 1);
      end
      else if (pulseCnt_r != 32'h0)
        pulseCnt_r <= pulseCnt_r - 32'h1;
      else
        pulse_r <= 1'b0;
    end
  end

  // power-good and reset delays share one setting
  assign goodAll = &(supplyGood | ~mask_r);
  always_ff @(posedge clock or negedge rstN)
  begin
    if (!rstN)
    begin
      pgCnt_r <= 32'h0;
      pgOk_r <= 1'b0;
      rsCnt_r <= 32'h0;
      rsOk_r <= 1'b0;
    end
    else
    begin
      if (state_r != PMU_ON || !goodAll)
      begin
        pgCnt_r <= 32'h0;
        pgOk_r <= 1'b0;
      end
      else if (pgCnt_r == delayCycles(delay_r) - 32'h1)
        pgOk_r <= 1'b1;
      else
        pgCnt_r <= pgCnt_r + 32'h1;
      if (state_r == PMU_OFF || !resetSenseHigh)
      begin
        rsCnt_r <= 32'h0;
        rsOk_r <= 1'b0;
      end
      else if (rsCnt_r == delayCycles(delay_r) - 32'h1)
        rsOk_r <= 1'b1;
      else
        rsCnt_r <= rsCnt_r + 32'h1;
    end
  end

  // supply outputs registered; thermal flag overrides the converter enables
  always_ff @(posedge clock or negedge rstN)
  begin
    if (!rstN)
    begin
      buckOn <= 3'h0;
      linregOn <= 2'h0;
      linreg2Setting <= 6'h0;
    end
    else
    begin
      if (overTemp)
        buckOn <= 3'h0;
      else if (pinMode)
        buckOn <= (state_r == PMU_ON) ? buckEnablePins : 3'h0;
      else if (state_r == PMU_UP || state_r == PMU_ON || state_r == PMU_DOWN)
        buckOn <= (state_r == PMU_ON) ? 3'h7 : seqMask(seqSel, step_r);
      else
        buckOn <= 3'h0;
      if ((state_r == PMU_UP && step_r == 2'h3) || state_r == PMU_ON)
      begin
        linregOn[0] <= ctrl1_r[`PMU_C1_LR1_BIT] | auto_r[0];
        linregOn[1] <= ctrl1_r[`PMU_C1_LR2_BIT] | auto_r[1];
      end
      else
        linregOn <= 2'h0;
      linreg2Setting <= lr2_r[`PMU_LR2_FOLLOW_BIT] ? buck3Setting : lr2_r[5:0];
    end
  end
  assign buckDischarge = ~buckOn;

  // pin and status outputs
  assign sysRampOn = (state_r != PMU_OFF);
  assign serialActive = (state_r == PMU_ON);
  assign powerState = state_r;
  assign lockoutLevel = ctrl2_r;
  assign powerGoodOut = 1'b0;
  assign powerGoodOe = !pgOk_r || pulse_r;
  assign resetOut = 1'b0;
  assign resetOe = !rsOk_r;
  assign buttonWakeOut = 1'b0;
  assign buttonWakeOe = !btnDeb;

  // write channel capture; address and data may come in either order
  assign awready = !awHeld_r && !bvalid;
  assign wready = !wHeld_r && !bvalid;
  assign doWrite = awHeld_r && wHeld_r && !bvalid;
  always_ff @(posedge clock or negedge rstN)
  begin
    if (!rstN)
    begin
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      awAddr_r <= 8'h0;
      wData_r <= 32'h0;
      wStrb_r <= 4'h0;
      bvalid <= 1'b0;
      bresp <= `PMU_RESP_OKAY;
    end
    else
    begin
      if (awvalid && awready)
      begin
        awHeld_r <= 1'b1;
        awAddr_r <= awaddr;
      end
      if (wvalid && wready)
      begin
        wHeld_r <= 1'b1;
        wData_r <= wdata;
        wStrb_r <= wstrb;
      end
      if (doWrite)
      begin
        awHeld_r <= 1'b0;
        wHeld_r <= 1'b0;
        bvalid <= 1'b1;
        bresp <= (awAddr_r <= `PMU_OFS_STATUS && awAddr_r[1:0] == 2'h0) ?
          `PMU_RESP_OKAY : `PMU_RESP_SLVERR;
      end
      else if (bready)
        bvalid <= 1'b0;
    end
  end

  // control registers; writes land only while the bus is active
  always_ff @(posedge clock or negedge rstN)
  begin
    if (!rstN)
    begin
      ctrl1_r <= `PMU_RST_CTRL1;
      auto_r <= `PMU_RST_AUTO;
      mask_r <= `PMU_RST_MASK;
      delay_r <= `PMU_RST_DELAY;
      lr2_r <= `PMU_RST_LR2;
    end
    else if (regsDefault)
    begin
      ctrl1_r <= `PMU_RST_CTRL1;
      auto_r <= `PMU_RST_AUTO;
      mask_r <= `PMU_RST_MASK;
      delay_r <= `PMU_RST_DELAY;
      lr2_r <= `PMU_RST_LR2;
    end
    else if (doWrite && serialActive && wStrb_r[0])
    begin
      unique case (awAddr_r)
        `PMU_OFS_CTRL1: ctrl1_r <= wData_r[4:0];
        `PMU_OFS_AUTO: auto_r <= wData_r[1:0];
        `PMU_OFS_MASK: mask_r <= wData_r[4:0];
        `PMU_OFS_DELAY: delay_r <= wData_r[1:0];
        `PMU_OFS_LR2: lr2_r <= wData_r[6:0];
        default: ;
      endcase
    end
  end

  // lockout level survives the on-entry default load, cleared in OFF
  always_ff @(posedge clock or negedge rstN)
  begin
    if (!rstN)
      ctrl2_r <= `PMU_RST_CTRL2;
    else if (state_r == PMU_OFF || pulse_r)
      ctrl2_r <= `PMU_RST_CTRL2;
    else if (doWrite && serialActive && wStrb_r[0] && awAddr_r == `PMU_OFS_CTRL2)
      ctrl2_r <= wData_r[1:0];
  end

  // read channel, one cycle answer
  assign arready = !rvalid;
  always_ff @(posedge clock or negedge rstN)
  begin
    if (!rstN)
    begin
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= `PMU_RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      rvalid <= 1'b1;
      rresp <= `PMU_RESP_OKAY;
      unique case (araddr)
        `PMU_OFS_CTRL1: rdata <= {27'h0, ctrl1_r};
        `PMU_OFS_CTRL2: rdata <= {30'h0, ctrl2_r};
        `PMU_OFS_AUTO: rdata <= {30'h0, auto_r};
        `PMU_OFS_MASK: rdata <= {27'h0, mask_r};
        `PMU_OFS_DELAY: rdata <= {30'h0, delay_r};
        `PMU_OFS_LR2: rdata <= {25'h0, lr2_r};
        `PMU_OFS_STATUS: rdata <= {25'h0, overTemp, rsOk_r, pgOk_r, btnDeb, state_r};
        default:
        begin
          rdata <= 32'h0;
          rresp <= `PMU_RESP_SLVERR;
        end
      endcase
    end
    else if (rready)
      rvalid <= 1'b0;
  end
endmodule

/* tb/pmu_host_model.sv */
// host processor model driving hold-on with a programmable lag
`timescale 1ns/1ps
module pmu_host_model (
  input wire logic clock, // system clock
  input wire logic keep, // bench wants the device kept on
  input wire logic [3:0] lag, // cycles before hold-on follows
  output logic holdOn // hold-on to the device
);
  logic [3:0] cnt;
  initial holdOn = 1'b0;
  initial cnt = 4'h0;
  // hold-on follows the wish after lag cycles; slow hosts exist
  always @(posedge clock)
    if (keep == holdOn)
      cnt <= 4'h0;
    else if (cnt >= lag)
      holdOn <= keep;
    else
      cnt <= cnt + 4'h1;
endmodule

/* tb/pmu_power_state_sequencer_tb.sv */
// self-checking bench for the power-state sequencer
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("[FAIL] %0t got %0h want %0h", $time, (g), (e)); end end
module pmu_power_state_sequencer_tb;
  import pmu_pkg::*;
  logic clock = 0, nrst = 0, powerButtonN = 1, extPowerPresent = 0, lockoutOk = 1;
  logic overTemp = 0, resetSenseHigh = 0, keep = 0, holdOn;
  logic [4:0] supplyGood = 0;
  logic [2:0] buckEnablePins = 0, buckOn, buckDischarge;
  logic [5:0] buck3Setting = 0, linreg2Setting;
  logic [1:0] linregOn, lockoutLevel, bresp, rresp;
  logic [3:0] lag = 0, wstrb = 4'hf;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic sysRampOn, serialActive, powerGoodOe, resetOe, buttonWakeOe;
  logic powerGoodOut, resetOut, buttonWakeOut;
  logic awready, wready, bvalid, arready, rvalid;
  pmu_state_t powerState;
  int mismatches = 0, n_checks = 0, cycles = 0;
  pmu_sequencer #(.DebounceCycles(8), .LongPressCycles(64), .PulseCycles(4),
    .RampCycles(4), .StepCycles(4), .DelayUnitCycles(4)) u_pmu_sequencer (.*);
  pmu_host_model u_pmu_host_model (.clock(clock), .keep(keep), .lag(lag), .holdOn(holdOn));
  // 50 MHz clock
  always #10 clock = ~clock;
  // verdict and end of run
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // hang guard
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      conclude();
    end
  end
  // one write; address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(negedge clock);
      aw = awvalid && awready;
      w = wvalid && wready;
      b = bvalid;
      @(posedge clock);
      if (aw)
        awvalid <= 1'b0;
      if (w)
        wvalid <= 1'b0;
    end
    while (!b);
    bready <= 1'b0;
  endtask
  // one read; inputs are stable between edges, so the negedge view is the edge view
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar, v;
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(negedge clock);
      ar = arvalid && arready;
      v = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clock);
      if (ar)
        arvalid <= 1'b0;
    end
    while (!v);
    rready <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    `CHK(d, e)
    `CHK(r, 2'h0)
  endtask
  task automatic waitSt(input pmu_state_t s);
    for (int i = 0; i < 300 && powerState !== s; i++)
      @(negedge clock);
    `CHK(powerState, s)
  endtask
  // defaults, unmapped word, write refused while off
  task automatic sRegs();
    logic [31:0] d;
    logic [1:0] r;
    `CHK(buckDischarge, 3'h7)
    `CHK({powerGoodOut, resetOut, buttonWakeOut}, 3'h0)
    rchk(8'h08, 32'h3);
    rchk(8'h0c, 32'h1f);
    rchk(8'h14, 32'h0);
    rd(8'h1c, d, r);
    `CHK(r, 2'h2)
    wr(8'h00, 32'h5);
    rchk(8'h00, 32'h0);
  endtask
  // press, sequence up, host keeps it on past release
  task automatic sUp();
    @(posedge clock);
    powerButtonN <= 1'b0;
    waitSt(PMU_ON);
    @(negedge clock);
    `CHK({buckOn, linregOn, serialActive, sysRampOn, buttonWakeOe}, 8'hff)
    @(posedge clock);
    keep <= 1'b1;
    repeat (4) @(posedge clock);
    powerButtonN <= 1'b1;
    repeat (30) @(negedge clock);
    `CHK({powerState, buttonWakeOe}, {PMU_ON, 1'b0})
  endtask
  // pin mode versus ordered mode
  task automatic sPins();
    wr(8'h04, 32'h2);
    wr(8'h00, 32'h5);
    @(posedge clock);
    buckEnablePins <= 3'h2;
    repeat (4) @(negedge clock);
    `CHK({buckOn, buckDischarge, lockoutLevel}, 8'h56)
    wr(8'h00, 32'h1);
    @(posedge clock);
    buckEnablePins <= 3'h5;
    repeat (4) @(negedge clock);
    `CHK(buckOn, 3'h7)
  endtask
  // regulator enables and follow mode
  task automatic sReg2();
    wr(8'h08, 32'h0);
    wr(8'h00, 32'h8);
    repeat (2) @(negedge clock);
    `CHK(linregOn, 2'h1)
    wr(8'h00, 32'h10);
    wr(8'h14, 32'h40);
    @(posedge clock);
    buck3Setting <= 6'h2a;
    repeat (3) @(negedge clock);
    `CHK({linregOn, linreg2Setting}, 8'haa)
    wr(8'h14, 32'h15);
    repeat (3) @(negedge clock);
    `CHK(linreg2Setting, 6'h15)
    // a write without the low byte strobe must leave the register alone
    @(posedge clock);
    wstrb <= 4'he;
    wr(8'h14, 32'h2a);
    wstrb <= 4'hf;
    rchk(8'h14, 32'h15);
  endtask
  // delayed release of power-good and reset, 8 cycle delay
  task automatic sGood();
    wr(8'h10, 32'h1);
    @(posedge clock);
    supplyGood <= 5'h1f;
    resetSenseHigh <= 1'b1;
    repeat (4) @(negedge clock);
    `CHK({powerGoodOe, resetOe}, 2'h3)
    repeat (10) @(negedge clock);
    `CHK({powerGoodOe, resetOe}, 2'h0)
    @(posedge clock);
    supplyGood <= 5'h1b;
    repeat (2) @(negedge clock);
    `CHK(powerGoodOe, 1'b1)
    // unmasking the low supply lets power-good go again
    wr(8'h0c, 32'h1b);
    repeat (10) @(negedge clock);
    `CHK(powerGoodOe, 1'b0)
    @(posedge clock);
    supplyGood <= 5'h1f;
  endtask
  // thermal stop and resume
  task automatic sHeat();
    @(posedge clock);
    overTemp <= 1'b1;
    repeat (2) @(negedge clock);
    `CHK(buckOn, 3'h0)
    @(posedge clock);
    overTemp <= 1'b0;
    repeat (3) @(negedge clock);
    `CHK(buckOn, 3'h7)
  endtask
  // long press: one pulse, defaults back, no second pulse
  task automatic sLong();
    int n;
    // power-good must be released first, or the pulse wait below ends at once
    repeat (12) @(negedge clock);
    `CHK(powerGoodOe, 1'b0)
    @(posedge clock);
    powerButtonN <= 1'b0;
    for (n = 0; n < 200 && !powerGoodOe; n++)
      @(negedge clock);
    `CHK(powerGoodOe, 1'b1)
    rchk(8'h00, 32'h0);
    rchk(8'h04, 32'h0);
    rchk(8'h08, 32'h3);
    repeat (20) @(negedge clock);
    n = 0;
    repeat (120) @(negedge clock) n += powerGoodOe;
    `CHK(n, 0)
    @(posedge clock);
    powerButtonN <= 1'b1;
    repeat (30) @(negedge clock);
  endtask
  // slow host drops hold-on during a press
  task automatic sDrop();
    logic off = 0, down = 0;
    @(posedge clock);
    lag <= 4'h2;
    powerButtonN <= 1'b0;
    for (int i = 0; i < 50 && !buttonWakeOe; i++)
      @(negedge clock);
    @(posedge clock);
    keep <= 1'b0;
    repeat (10) @(negedge clock)
    begin
      off |= powerState === PMU_OFF;
      down |= powerState === PMU_DOWN;
    end
    `CHK({off, down}, 2'b10)
    @(posedge clock);
    lockoutOk <= 1'b0;
    powerButtonN <= 1'b1;
    repeat (30) @(negedge clock);
    `CHK(powerState, PMU_OFF)
  endtask
  // external power start, then lockout
  task automatic sExt();
    @(posedge clock);
    lockoutOk <= 1'b1;
    extPowerPresent <= 1'b1;
    keep <= 1'b1;
    lag <= 4'h0;
    waitSt(PMU_ON);
    @(posedge clock);
    lockoutOk <= 1'b0;
    repeat (2) @(negedge clock);
    `CHK(powerState, PMU_OFF)
    @(posedge clock);
    extPowerPresent <= 1'b0;
    keep <= 1'b0;
    lockoutOk <= 1'b1;
    repeat (10) @(negedge clock);
  endtask
  // release without hold-on: ordered stop, lockout bits kept till off
  task automatic sDown();
    @(posedge clock);
    powerButtonN <= 1'b0;
    waitSt(PMU_ON);
    wr(8'h04, 32'h3);
    @(posedge clock);
    powerButtonN <= 1'b1;
    waitSt(PMU_DOWN);
    `CHK(lockoutLevel, 2'h3)
    waitSt(PMU_OFF);
    repeat (2) @(negedge clock);
    `CHK(lockoutLevel, 2'h0)
  endtask
  // main sequence
  initial
  begin
    repeat (4) @(posedge clock);
    nrst <= 1'b1;
    repeat (3) @(posedge clock);
    sRegs();
    sUp();
    sPins();
    sReg2();
    sGood();
    sHeat();
    sLong();
    sDrop();
    sExt();
    sDown();
    conclude();
  end
endmodule
bind pmu_sequencer pmu_seq_sva #(.DebounceCycles(DebounceCycles)) u_pmu_seq_sva (
  .clock(clock), .nrst(nrst), .powerButtonN(powerButtonN), .lockoutOk(lockoutOk),
  .overTemp(overTemp), .buckOn(buckOn), .buckDischarge(buckDischarge),
  .serialActive(serialActive), .powerState(powerState), .powerGoodOe(powerGoodOe),
  .resetOe(resetOe), .buttonWakeOe(buttonWakeOe), .bvalid(bvalid), .bready(bready),
  .bresp(bresp), .rvalid(rvalid), .rready(rready), .rdata(rdata));

/* tb/pmu_seq_sva.sv */
// assertion checker bound to the power-state sequencer ports
`timescale 1ns/1ps
module pmu_seq_sva #(
  parameter int DebounceCycles = 8
) (
  input wire logic clock, // system clock
  input wire logic nrst, // reset, active low
  input wire logic powerButtonN, // button level
  input wire logic lockoutOk, // rail valid
  input wire logic overTemp, // thermal flag
  input wire logic [2:0] buckOn, // converter run
  input wire logic [2:0] buckDischarge, // discharge switch
  input wire logic serialActive, // bus live
  input pmu_pkg::pmu_state_t powerState, // state
  input wire logic powerGoodOe, // power-good pulled low
  input wire logic resetOe, // reset pulled low
  input wire logic buttonWakeOe, // wake pulled low
  input wire logic bvalid, // axi
  input wire logic bready, // axi
  input wire logic [1:0] bresp, // axi
  input wire logic rvalid, // axi
  input wire logic rready, // axi
  input wire logic [31:0] rdata // axi
);
  import pmu_pkg::*;
  int lowCnt;
  default clocking @(posedge clock);
  endclocking
  default disable iff (!nrst);
  // cycles the raw button has been held low, saturating
  always_ff @(posedge clock or negedge nrst)
    if (!nrst)
      lowCnt <= 0;
    else if (powerButtonN)
      lowCnt <= 0;
    else if (lowCnt < 1000)
      lowCnt <= lowCnt + 1;
  AST_DISCHARGE:
    assert property (buckDischarge == ~buckOn) else $error("discharge not inverse of run");
  AST_IDLE_OFF:
    assert property ((powerState == PMU_OFF) [*2] |-> buckOn == 3'h0 && resetOe)
    else $error("activity while off");
  AST_HEAT:
    assert property (overTemp |=> buckOn == 3'h0) else $error("converter ran while hot");
  AST_BUS:
    assert property (serialActive == (powerState == PMU_ON)) else $error("bus live outside on");
  AST_START:
    assert property (powerState == PMU_OFF && !lockoutOk |=> powerState == PMU_OFF)
    else $error("start without valid rail");
  AST_LOCKOUT:
    assert property (!lockoutOk && powerState inside {PMU_RAMP, PMU_UP, PMU_ON, PMU_DOWN}
      |=> powerState == PMU_OFF) else $error("lockout ignored");
  AST_PG_OUT:
    assert property ((powerState != PMU_ON) [*2] |-> powerGoodOe) else $error("good outside on");
  AST_WAKE:
    assert property ($rose(buttonWakeOe) |-> lowCnt >= DebounceCycles)
    else $error("wake before debounce");
  AST_BRESP:
    assert property (bvalid && !bready |=> bvalid && $stable(bresp)) else $error("bresp dropped");
  AST_RDATA:
    assert property (rvalid && !rready |=> rvalid && $stable(rdata)) else $error("rdata dropped");
endmodule
